// ===== logic/sbr_ctl.sv
// controller end: issues commands, drives write data, paces masks and recovery
`timescale 1ns/1ps
module sbr_ctl (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [sbr_pkg::LW-1:0]   read_latency,
  input  wire logic [sbr_pkg::SW-1:0]   burst_sel,
  input  wire logic                     req_valid,
  input  wire sbr_pkg::sbr_cmd_t        req_cmd,
  input  wire logic [sbr_pkg::BW-1:0]   req_bank,
  input  wire logic [sbr_pkg::AW-1:0]   req_addr,
  input  wire logic                     req_dqm,
  input  wire logic [sbr_pkg::DW-1:0]   req_wdata,
  output logic                          req_ready,
  output logic [sbr_pkg::DW-1:0]        rd_data,
  output logic                          rd_valid,
  sbr_if.ctl                            bus
);
  typedef struct packed {
    sbr_pkg::sbr_cmd_t                      cmd;
    logic [sbr_pkg::BW-1:0]                 bank;
    logic [sbr_pkg::AW-1:0]                 addr;
    logic                                   dqm;
    logic [sbr_pkg::DW-1:0]                 dq;
    logic                                   oe;
    logic                                   hv;
    sbr_pkg::sbr_cmd_t                      h_cmd;
    logic [sbr_pkg::BW-1:0]                 h_bank;
    logic [sbr_pkg::AW-1:0]                 h_addr;
    logic                                   h_dqm;
    logic [sbr_pkg::DW-1:0]                 h_wd;
    logic                                   ready;
    logic [sbr_pkg::DW-1:0]                 rdata;
    logic                                   rvalid;
    logic [sbr_pkg::NB-1:0][sbr_pkg::TW-1:0] precharge_recovery_time;
    logic [sbr_pkg::RW-1:0]                 rd_left;
    logic                                   rd_open;
    logic [sbr_pkg::CW-1:0]                 wr_left;
    logic                                   wr_open;
    logic [1:0]                             dqm_run;
  } sbr_ctl_st_t;

  sbr_ctl_st_t                cur_ff;
  sbr_ctl_st_t                nxt_st;
  logic                       c_v;
  sbr_pkg::sbr_cmd_t          c_cmd;
  logic [sbr_pkg::BW-1:0]     c_bank;
  logic [sbr_pkg::AW-1:0]     c_addr;
  logic                       c_dqm;
  logic [sbr_pkg::DW-1:0]     c_wd;
  logic [sbr_pkg::CW-1:0]     mask;
  logic                       lead;
  logic                       ok;

  // ==========================================================
  // a refused request is parked and retried; ready drops while parked
  always_comb begin
    nxt_st = cur_ff;
    mask   = sbr_pkg::sbr_bl_mask(burst_sel);
    c_v    = cur_ff.hv | (req_valid & cur_ff.ready);
    c_cmd  = cur_ff.hv ? cur_ff.h_cmd  : req_cmd;
    c_bank = cur_ff.hv ? cur_ff.h_bank : req_bank;
    c_addr = cur_ff.hv ? cur_ff.h_addr : req_addr;
    c_dqm  = cur_ff.hv ? cur_ff.h_dqm  : req_dqm;
    c_wd   = cur_ff.hv ? cur_ff.h_wd   : req_wdata;
    nxt_st.rvalid = bus.dq_d_oe;
    nxt_st.rdata  = bus.dq_d;
    nxt_st.cmd = sbr_pkg::CMD_NOP;
    nxt_st.dqm = 1'b0;
    nxt_st.oe  = 1'b0;
    for (int i = 0; i < sbr_pkg::NB; i++) begin
      if (cur_ff.precharge_recovery_time[i] != '0) begin
        nxt_st.precharge_recovery_time[i] = cur_ff.precharge_recovery_time[i] - 4'h1;
      end
    end
    if (!cur_ff.rd_open && (cur_ff.rd_left != '0)) begin
      nxt_st.rd_left = cur_ff.rd_left - 10'h001;
    end
    if (cur_ff.wr_open || (cur_ff.wr_left != '0)) begin
      // a beat with no data from the user is masked
      nxt_st.oe  = 1'b1;
      nxt_st.dqm = 1'b1;
      if (!cur_ff.wr_open) begin
        nxt_st.wr_left = cur_ff.wr_left - 8'h01;
      end
    end
    // reads still owning the wire need a two clock mask lead before a write, except at burst of one
    lead = (cur_ff.rd_open || (cur_ff.rd_left != '0)) && (burst_sel != sbr_pkg::BL_1);
    ok   = (c_cmd == sbr_pkg::CMD_NOP) ||
           ((cur_ff.precharge_recovery_time[c_bank] == '0) &&
            ((c_cmd != sbr_pkg::CMD_WR) || !lead || (cur_ff.dqm_run >= sbr_pkg::DQM_OUT_LEAD)));
    if (c_v && ok) begin
      nxt_st.hv   = 1'b0;
      nxt_st.cmd  = c_cmd;
      nxt_st.bank = c_bank;
      nxt_st.addr = c_addr;
      nxt_st.dqm  = c_dqm;
      nxt_st.dq   = c_wd;
      case (c_cmd)
        sbr_pkg::CMD_RD: begin
          nxt_st.rd_left = sbr_pkg::RW'(mask) + 10'h001 + sbr_pkg::RW'(read_latency);
          nxt_st.rd_open = (burst_sel == sbr_pkg::BL_FULL);
          nxt_st.wr_left = '0;
          nxt_st.wr_open = 1'b0;
          nxt_st.oe      = 1'b0;
        end
        sbr_pkg::CMD_WR: begin
          nxt_st.oe      = 1'b1;
          nxt_st.wr_left = mask;
          nxt_st.wr_open = (burst_sel == sbr_pkg::BL_FULL);
          nxt_st.rd_left = '0;
          nxt_st.rd_open = 1'b0;
        end
        sbr_pkg::CMD_PRE, sbr_pkg::CMD_BST: begin
          // words already in the device pipe still arrive
          if (cur_ff.rd_open || (cur_ff.rd_left != '0)) begin
            nxt_st.rd_left = sbr_pkg::RW'(read_latency);
          end
          nxt_st.rd_open = 1'b0;
          nxt_st.wr_left = '0;
          nxt_st.wr_open = 1'b0;
          nxt_st.oe      = 1'b0;
          if (c_cmd == sbr_pkg::CMD_PRE) begin
            for (int i = 0; i < sbr_pkg::NB; i++) begin
              if (c_addr[sbr_pkg::AP_BIT] || (c_bank == sbr_pkg::BW'(i))) begin
                nxt_st.precharge_recovery_time[i] = sbr_pkg::TRP_LOAD;
              end
            end
          end
        end
        default: ;
      endcase
    end else if (c_v) begin
      nxt_st.hv     = 1'b1;
      nxt_st.h_cmd  = c_cmd;
      nxt_st.h_bank = c_bank;
      nxt_st.h_addr = c_addr;
      nxt_st.h_dqm  = c_dqm;
      nxt_st.h_wd   = c_wd;
      if ((c_cmd == sbr_pkg::CMD_WR) && lead) begin
        nxt_st.dqm = 1'b1;
      end
    end
    nxt_st.ready   = ~nxt_st.hv;
    nxt_st.dqm_run = !nxt_st.dqm ? 2'h0 :
                     (cur_ff.dqm_run == 2'h3) ? 2'h3 : cur_ff.dqm_run + 2'h1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign bus.cmd     = cur_ff.cmd;
  assign bus.bank    = cur_ff.bank;
  assign bus.addr    = cur_ff.addr;
  assign bus.dqm     = cur_ff.dqm;
  assign bus.dq_c    = cur_ff.dq;
  assign bus.dq_c_oe = cur_ff.oe;
  assign req_ready   = cur_ff.ready;
  assign rd_data     = cur_ff.rdata;
  assign rd_valid    = cur_ff.rvalid;
endmodule // sbr_ctl

// ===== logic/sbr_pkg.sv
// shared constants, commands and states of the burst read/write link
package sbr_pkg;

  // ==========================================================
  // widths
  localparam int DW         = 32;
  localparam int BW         = 2;
  localparam int NB         = 4;
  localparam int AW         = 11;
  localparam int CW         = 8;
  localparam int IW         = BW + CW;
  localparam int RW         = CW + 2;
  localparam int AP_BIT     = 10;
  localparam int LW         = 2;
  localparam int SW         = 3;
  localparam int TW         = 4;
  localparam int PIPE_DEPTH = 3;

  // ==========================================================
  // mode inputs
  localparam logic [LW-1:0] LAT_2   = 2'h2;
  localparam logic [LW-1:0] LAT_3   = 2'h3;
  localparam logic [SW-1:0] BL_1    = 3'h0;
  localparam logic [SW-1:0] BL_2    = 3'h1;
  localparam logic [SW-1:0] BL_4    = 3'h2;
  localparam logic [SW-1:0] BL_8    = 3'h3;
  localparam logic [SW-1:0] BL_FULL = 3'h7;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS           = 10;
  localparam int PRECHARGE_RECOVERY_NS   = 20;
  localparam int PRECHARGE_RECOVERY_CYC  =
    (PRECHARGE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TW-1:0] TRP_LOAD     = TW'(PRECHARGE_RECOVERY_CYC);
  localparam logic [1:0]    DQM_OUT_LEAD = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST} sbr_cmd_t;
  typedef enum logic [1:0] {MODE_IDLE, MODE_RD, MODE_WR} sbr_mode_t;

  // column mask of the wrap block; full page spans the whole row
  function automatic logic [CW-1:0] sbr_bl_mask(input logic [SW-1:0] sel);
    case (sel)
      BL_2:    return 8'h01;
      BL_4:    return 8'h03;
      BL_8:    return 8'h07;
      BL_FULL: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [CW-1:0] sbr_next_col(input logic [CW-1:0] col, input logic [CW-1:0] msk);
    logic [CW-1:0] inc;
    inc = col + 8'h01;
    return (col & ~msk) | (inc & msk);
  endfunction

endpackage

// ===== logic/sbr_if.sv
// command, address, mask and data lines between controller and device
`timescale 1ns/1ps
interface sbr_if;
  sbr_pkg::sbr_cmd_t          cmd;
  logic [sbr_pkg::BW-1:0]     bank;
  logic [sbr_pkg::AW-1:0]     addr;
  logic                       dqm;
  logic [sbr_pkg::DW-1:0]     dq_c;
  logic                       dq_c_oe;
  logic [sbr_pkg::DW-1:0]     dq_d;
  logic                       dq_d_oe;
  logic [sbr_pkg::DW-1:0]     dq;

  // wire level for observation; on contention the device value is shown
  assign dq = dq_d_oe ? dq_d : dq_c;

  modport dev (input cmd, bank, addr, dqm, dq_c, dq_c_oe, output dq_d, dq_d_oe);
  modport ctl (output cmd, bank, addr, dqm, dq_c, dq_c_oe, input dq_d, dq_d_oe);
endinterface

// ===== logic/sbr_pipe.sv
// read data latency pipeline with output-side mask and flush
`timescale 1ns/1ps
module sbr_pipe (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [sbr_pkg::LW-1:0]   lat,
  input  wire logic                     in_v,
  input  wire logic [sbr_pkg::DW-1:0]   in_d,
  input  wire logic                     kill,
  input  wire logic                     flush,
  output logic [sbr_pkg::DW-1:0]        out_d,
  output logic                          out_v
);
  localparam int LAST = sbr_pkg::PIPE_DEPTH - 1;

  typedef struct packed {
    logic [sbr_pkg::PIPE_DEPTH-1:0]                   v;
    logic [sbr_pkg::PIPE_DEPTH-1:0][sbr_pkg::DW-1:0]  d;
  } sbr_pipe_st_t;

  sbr_pipe_st_t cur_ff;
  sbr_pipe_st_t nxt_st;
  int           entry;

  // ==========================================================
  // entering nearer the output shortens the latency; a bad code acts as 3
  always_comb begin
    nxt_st = cur_ff;
    entry  = (lat == sbr_pkg::LAT_2) ? sbr_pkg::PIPE_DEPTH - 2 : sbr_pkg::PIPE_DEPTH - 3;
    for (int i = 0; i < sbr_pkg::PIPE_DEPTH; i++) begin
      if (i == entry) begin
        nxt_st.v[i] = in_v;
        nxt_st.d[i] = in_d;
      end else if (i == 0) begin
        nxt_st.v[i] = 1'b0;
      end else begin
        nxt_st.v[i] = cur_ff.v[i-1];
        nxt_st.d[i] = cur_ff.d[i-1];
      end
    end
    nxt_st.v[LAST] = nxt_st.v[LAST] & ~kill;
    if (flush) begin
      nxt_st.v = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign out_d = cur_ff.d[LAST];
  assign out_v = cur_ff.v[LAST];
endmodule // sbr_pipe

// ===== logic/sbr_dev.sv
// device end: burst engine, storage array and read output path
`timescale 1ns/1ps
// ============================================================
// Summary of operation
// - READ brings start column, bank, precharge choice
// - auto precharge closes row after burst
// - first read word after latency, then one/clock
// - finished read burst releases data lines
// - full page runs on, wraps to column 0
// - READ truncates read, seamless data, latency-1 lead
// - READ accepted every clock, any bank
// - WRITE after read needs contention-free gap
// - mask kills read output two clocks later
// - registered WRITE keeps device lines released
// - mask acts on input data same edge
// - PRECHARGE ends fixed read, latency-1 lead
// - no bank command before precharge recovery
// - timely PRECHARGE equals auto precharge burst
// - BURST TERMINATE ends read, latency-1 lead
// - write word taken with WRITE, then one/clock
// - after fixed write, input data ignored
// - WRITE truncates WRITE, new data new burst
// - WRITE accepted every clock, any bank
// - burst of one needs no mask before WRITE
// - read latency two or three clocks
// - address bit ten requests auto precharge
module sbr_dev (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [sbr_pkg::LW-1:0]   read_latency,
  input  wire logic [sbr_pkg::SW-1:0]   burst_sel,
  output logic [sbr_pkg::NB-1:0]        bank_open,
  output logic                          burst_active,
  sbr_if.dev                            bus
);
  typedef struct packed {
    sbr_pkg::sbr_mode_t         mode;
    logic [sbr_pkg::BW-1:0]     bank;
    logic [sbr_pkg::CW-1:0]     col;
    logic [sbr_pkg::CW-1:0]     msk;
    logic [sbr_pkg::CW-1:0]     left;
    logic                       full;
    logic                       ap;
    logic                       dqm_d;
    logic [sbr_pkg::NB-1:0]     open;
    logic                       active;
  } sbr_dev_st_t;

  sbr_dev_st_t                cur_ff;
  sbr_dev_st_t                nxt_st;

  logic [sbr_pkg::DW-1:0]     mem [0:(1 << sbr_pkg::IW) - 1];
  logic [sbr_pkg::CW-1:0]     mask;
  logic [sbr_pkg::CW-1:0]     col0;
  logic                       take;
  logic                       rd_v;
  logic [sbr_pkg::IW-1:0]     rd_a;
  logic [sbr_pkg::DW-1:0]     rd_d;
  logic                       mem_we;
  logic [sbr_pkg::IW-1:0]     mem_wa;
  logic [sbr_pkg::DW-1:0]     mem_wd;
  logic                       flush;

  // ============================================================
  // command decode and burst stepping
  always_comb begin
    nxt_st = cur_ff;
    mask   = sbr_pkg::sbr_bl_mask(burst_sel);
    col0   = bus.addr[sbr_pkg::CW-1:0];
    rd_v   = 1'b0;
    rd_a   = {cur_ff.bank, cur_ff.col};
    mem_we = 1'b0;
    mem_wa = {cur_ff.bank, cur_ff.col};
    mem_wd = bus.dq_c;
    flush  = 1'b0;
    nxt_st.dqm_d = bus.dqm;

    // a command that ends or replaces the running burst stops its step
    take = (bus.cmd == sbr_pkg::CMD_RD) || (bus.cmd == sbr_pkg::CMD_WR) ||
           (bus.cmd == sbr_pkg::CMD_BST) ||
           ((bus.cmd == sbr_pkg::CMD_PRE) &&
            (bus.addr[sbr_pkg::AP_BIT] || (bus.bank == cur_ff.bank)));

    if (!take && (cur_ff.mode != sbr_pkg::MODE_IDLE)) begin
      if (cur_ff.mode == sbr_pkg::MODE_RD) begin
        rd_v = 1'b1;
      end else begin
        mem_we = ~bus.dqm;
      end
      nxt_st.col = sbr_pkg::sbr_next_col(cur_ff.col, cur_ff.msk);
      if (!cur_ff.full) begin
        nxt_st.left = cur_ff.left - 8'h01;
        if (cur_ff.left == 8'h01) begin
          // idle engine feeds nothing, so the read lines fall released
          nxt_st.mode = sbr_pkg::MODE_IDLE;
          if (cur_ff.ap) begin
            nxt_st.open[cur_ff.bank] = 1'b0;
          end
        end
      end
    end

    case (bus.cmd)
      sbr_pkg::CMD_RD, sbr_pkg::CMD_WR: begin
        // an interrupted auto precharge burst closes its row right away
        if ((cur_ff.mode != sbr_pkg::MODE_IDLE) && cur_ff.ap) begin
          nxt_st.open[cur_ff.bank] = 1'b0;
        end
        nxt_st.bank = bus.bank;
        nxt_st.msk  = mask;
        nxt_st.col  = sbr_pkg::sbr_next_col(col0, mask);
        nxt_st.left = mask;
        nxt_st.full = (burst_sel == sbr_pkg::BL_FULL);
        // auto precharge never applies to full page, and never carries over
        nxt_st.ap   = bus.addr[sbr_pkg::AP_BIT] && (burst_sel != sbr_pkg::BL_FULL);
        if (bus.cmd == sbr_pkg::CMD_RD) begin
          nxt_st.mode = sbr_pkg::MODE_RD;
          rd_v = 1'b1;
          rd_a = {bus.bank, col0};
        end else begin
          nxt_st.mode = sbr_pkg::MODE_WR;
          flush  = 1'b1;
          mem_we = ~bus.dqm;
          mem_wa = {bus.bank, col0};
        end
        if (mask == 8'h00) begin
          nxt_st.mode = sbr_pkg::MODE_IDLE;
          if (nxt_st.ap) begin
            nxt_st.open[bus.bank] = 1'b0;
          end
        end
      end
      sbr_pkg::CMD_PRE: begin
        if (bus.addr[sbr_pkg::AP_BIT]) begin
          nxt_st.open = '0;
        end else begin
          nxt_st.open[bus.bank] = 1'b0;
        end
        if (take) begin
          nxt_st.mode = sbr_pkg::MODE_IDLE;
        end
      end
      sbr_pkg::CMD_BST: begin
        nxt_st.mode = sbr_pkg::MODE_IDLE;
      end
      sbr_pkg::CMD_ACT: begin
        nxt_st.open[bus.bank] = 1'b1;
      end
      default: ;
    endcase

    nxt_st.active = (nxt_st.mode != sbr_pkg::MODE_IDLE);
  end

  // ============================================================
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ============================================================
  // storage; no reset so the array maps onto plain memory
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign rd_d = mem[rd_a];

  // ============================================================
  // output path: latency pipe, mask delayed by one here and one in the pipe
  sbr_pipe u_pipe (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lat     (read_latency),
    .in_v    (rd_v),
    .in_d    (rd_d),
    .kill    (cur_ff.dqm_d),
    .flush   (flush),
    .out_d   (bus.dq_d),
    .out_v   (bus.dq_d_oe)
  );

  assign bank_open    = cur_ff.open;
  assign burst_active = cur_ff.active;
endmodule // sbr_dev

// ===== verification/sbr_link_properties.sv
// concurrent checks on the lines between controller and device
`timescale 1ns/1ps
module sbr_link_properties (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic [sbr_pkg::LW-1:0] read_latency,
  input wire logic [sbr_pkg::SW-1:0] burst_sel,
  input wire sbr_pkg::sbr_cmd_t      cmd,
  input wire logic [sbr_pkg::BW-1:0] bank,
  input wire logic [sbr_pkg::AW-1:0] addr,
  input wire logic                   dqm,
  input wire logic                   dq_c_oe,
  input wire logic                   dq_d_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic rd;
  logic nop;
  logic lat2;
  logic lat3;
  logic bl1;
  logic ap;
  assign rd   = cmd == sbr_pkg::CMD_RD;
  assign nop  = cmd == sbr_pkg::CMD_NOP;
  assign lat2 = read_latency == sbr_pkg::LAT_2;
  assign lat3 = read_latency == sbr_pkg::LAT_3;
  assign bl1  = burst_sel == sbr_pkg::BL_1;
  assign ap   = addr[sbr_pkg::AP_BIT];

  // ==========================================================
  // read output timing
  AST_RD_LAT2: assert property ((lat2 && rd && !dqm) ##1 nop |=> dq_d_oe)
    else $error("first read word missing at latency two");
  AST_RD_LAT3: assert property ((lat3 && rd && !dqm) ##1 (nop && !dqm) ##1 nop |=> dq_d_oe)
    else $error("first read word missing at latency three");
  AST_RD_BACK2BACK: assert property ((lat2 && rd && !dqm) [*2] ##1 nop |-> dq_d_oe ##1 dq_d_oe)
    else $error("gap between truncated and new read data");
  AST_BL1_RELEASE: assert property ((bl1 && lat2 && rd) ##1 (bl1 && nop) [*2] |=> !dq_d_oe)
    else $error("data lines held after single read");
  AST_BST_STOP: assert property ((lat2 && cmd == sbr_pkg::CMD_BST) ##1 nop |=> !dq_d_oe)
    else $error("read word after burst terminate");

  // ==========================================================
  // turnaround and mask
  AST_DQM_KILL: assert property (dqm |-> ##2 !dq_d_oe)
    else $error("read word driven two clocks after mask");
  AST_WR_RELEASE: assert property (cmd == sbr_pkg::CMD_WR |=> !dq_d_oe)
    else $error("device drives after write");
  AST_WR_DRIVES: assert property (cmd == sbr_pkg::CMD_WR |-> dq_c_oe)
    else $error("write issued without data");
  AST_NO_CONTENTION: assert property (!(dq_d_oe && dq_c_oe))
    else $error("both ends drive data lines");

  // ==========================================================
  // bank recovery
  AST_PRE_RECOVERY: assert property (cmd == sbr_pkg::CMD_PRE |=>
    nop || (!$past(ap) && bank != $past(bank)))
    else $error("command to bank inside recovery");
endmodule // sbr_link_properties

// ===== verification/sbr_burst_read_write_bench.sv
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module sbr_burst_read_write_bench;
  logic                   ref_clk   = 1'b0;
  logic                   rst       = 1'b1;
  logic [sbr_pkg::LW-1:0] lat       = sbr_pkg::LAT_2;
  logic [sbr_pkg::SW-1:0] bsel      = sbr_pkg::BL_4;
  logic                   req_valid = 1'b0;
  sbr_pkg::sbr_cmd_t      req_cmd   = sbr_pkg::CMD_NOP;
  logic [sbr_pkg::BW-1:0] req_bank  = 2'h0;
  logic [sbr_pkg::AW-1:0] req_addr  = 11'h000;
  logic                   req_dqm   = 1'b0;
  logic [sbr_pkg::DW-1:0] req_wdata = 32'h0;
  logic                   req_ready;
  logic [sbr_pkg::DW-1:0] rd_data;
  logic                   rd_valid;
  logic [sbr_pkg::NB-1:0] bank_open;
  logic                   busy;
  logic [15:0]            lfsr      = 16'h5A1E;
  logic [sbr_pkg::DW-1:0] mem [4][256];
  logic [sbr_pkg::DW-1:0] exp_q [$];
  int                     errors    = 0;
  int                     checks    = 0;

  sbr_if link ();
  always #5 ref_clk = ~ref_clk;

  sbr_dev sbr_dev_inst (.ref_clk(ref_clk), .rst(rst), .read_latency(lat), .burst_sel(bsel),
    .bank_open(bank_open), .burst_active(busy), .bus(link.dev));
  sbr_ctl sbr_ctl_inst (.ref_clk(ref_clk), .rst(rst), .read_latency(lat), .burst_sel(bsel),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_dqm(req_dqm), .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .bus(link.ctl));
  sbr_link_properties sbr_link_properties_inst (.ref_clk(ref_clk), .rst(rst), .read_latency(lat),
    .burst_sel(bsel), .cmd(link.cmd), .bank(link.bank), .addr(link.addr), .dqm(link.dqm),
    .dq_c_oe(link.dq_c_oe), .dq_d_oe(link.dq_d_oe));

  // ==========================================================
  // helpers
  function automatic logic [7:0] col_at(input logic [7:0] col, input int k, input logic [7:0] m);
    return (col & ~m) | ((col + 8'(k)) & m);
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // held until an edge with ready high takes it
  task automatic req(input sbr_pkg::sbr_cmd_t c, input logic [1:0] b, input logic [10:0] a,
                     input logic m, input logic [31:0] d);
    int n;
    logic ok;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_dqm = m;
    req_wdata = d;
    n = 0;
    do begin
      @(posedge ref_clk);
      ok = req_ready;
      n++;
    end while (ok !== 1'b1 && n < 50);
    if (ok !== 1'b1) begin
      check("request taken", 32'h0, 32'h1);
      test_done();
    end
  endtask

  task automatic idle(input int k);
    @(negedge ref_clk);
    req_valid = 1'b0;
    repeat (k) @(posedge ref_clk);
    // end off the edge so mode changes and output checks never race the flops
    @(negedge ref_clk);
  endtask

  // beat numbered skip goes out masked and leaves the model untouched
  task automatic wr(input logic [1:0] b, input logic [7:0] col, input int n, input int skip,
                    input logic [7:0] m);
    logic [31:0] d;
    for (int k = 0; k < n; k++) begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr, ~lfsr};
      if (k != skip) mem[b][col_at(col, k, m)] = d;
      req(k == 0 ? sbr_pkg::CMD_WR : sbr_pkg::CMD_NOP, b, {3'h0, col}, k == skip, d);
    end
  endtask

  // n words expected; stop ends the burst just in time for the last one
  task automatic rd(input logic [1:0] b, input logic [7:0] col, input int n, input logic [7:0] m,
                    input logic ap, input logic stop);
    for (int k = 0; k < n; k++) exp_q.push_back(mem[b][col_at(col, k, m)]);
    req(sbr_pkg::CMD_RD, b, {ap, 2'h0, col}, 1'b0, 32'h0);
    if (stop) begin
      repeat (n - 1) req(sbr_pkg::CMD_NOP, b, 11'h000, 1'b0, 32'h0);
      req(sbr_pkg::CMD_BST, b, 11'h000, 1'b0, 32'h0);
    end
  endtask

  always @(negedge ref_clk) if (!rst && rd_valid === 1'b1) begin
    if (exp_q.size() == 0) check("extra word", 32'h1, 32'h0);
    else check("read word", rd_data, exp_q.pop_front());
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    @(posedge ref_clk);
    for (int b = 0; b < 4; b++) req(sbr_pkg::CMD_ACT, 2'(b), 11'h000, 1'b0, 32'h0);
    wr(2'h0, 8'h06, 4, 9, 8'h03);
    wr(2'h0, 8'h04, 4, 1, 8'h03);
    for (int i = 0; i < 2; i++) begin
      idle(2);
      lat = (i == 0) ? sbr_pkg::LAT_2 : sbr_pkg::LAT_3;
      rd(2'h0, 8'h05, 4, 8'h03, 1'b0, 1'b0);
      idle(8);
    end
    lat = sbr_pkg::LAT_2;
    rd(2'h0, 8'h04, 1, 8'h03, 1'b0, 1'b0);
    rd(2'h0, 8'h06, 4, 8'h03, 1'b0, 1'b0);
    // let the whole burst arrive; a write now would mask its tail
    idle(8);
    wr(2'h1, 8'h00, 1, 9, 8'h03);
    wr(2'h1, 8'h04, 4, 9, 8'h03);
    rd(2'h1, 8'h00, 1, 8'h03, 1'b0, 1'b0);
    rd(2'h1, 8'h04, 4, 8'h03, 1'b0, 1'b0);
    idle(8);
    // mask leads the write by two bus cycles so the tail of the read is dropped
    rd(2'h0, 8'h04, 1, 8'h03, 1'b0, 1'b0);
    req(sbr_pkg::CMD_NOP, 2'h0, 11'h000, 1'b1, 32'h0);
    req(sbr_pkg::CMD_NOP, 2'h0, 11'h000, 1'b1, 32'h0);
    wr(2'h0, 8'h08, 4, 9, 8'h03);
    idle(4);
    bsel = sbr_pkg::BL_FULL;
    wr(2'h3, 8'hFE, 4, 9, 8'hFF);
    req(sbr_pkg::CMD_BST, 2'h3, 11'h000, 1'b0, 32'h0);
    rd(2'h3, 8'hFF, 3, 8'hFF, 1'b0, 1'b1);
    idle(8);
    bsel = sbr_pkg::BL_1;
    rd(2'h0, 8'h09, 1, 8'h00, 1'b0, 1'b0);
    req(sbr_pkg::CMD_NOP, 2'h0, 11'h000, 1'b0, 32'h0);
    req(sbr_pkg::CMD_NOP, 2'h0, 11'h000, 1'b0, 32'h0);
    wr(2'h0, 8'h20, 1, 9, 8'h00);
    rd(2'h0, 8'h20, 1, 8'h00, 1'b0, 1'b0);
    idle(6);
    bsel = sbr_pkg::BL_2;
    rd(2'h0, 8'h05, 2, 8'h01, 1'b0, 1'b0);
    idle(8);
    check("banks open", 32'(bank_open), 32'hF);
    rd(2'h0, 8'h04, 2, 8'h01, 1'b1, 1'b0);
    idle(1);
    for (int n = 0; n < 10 && bank_open[0] !== 1'b0; n++) @(negedge ref_clk);
    check("auto precharge", 32'(bank_open), 32'hE);
    // fixed read followed by a precharge one clock before its last word
    exp_q.push_back(mem[1][4]);
    exp_q.push_back(mem[1][5]);
    req(sbr_pkg::CMD_RD, 2'h1, 11'h004, 1'b0, 32'h0);
    req(sbr_pkg::CMD_NOP, 2'h1, 11'h000, 1'b0, 32'h0);
    req(sbr_pkg::CMD_PRE, 2'h1, 11'h000, 1'b0, 32'h0);
    idle(4);
    check("bank after precharge", 32'(bank_open), 32'hC);
    req(sbr_pkg::CMD_ACT, 2'h0, 11'h000, 1'b0, 32'h0);
    req(sbr_pkg::CMD_PRE, 2'h0, 11'h000, 1'b0, 32'h0);
    req(sbr_pkg::CMD_ACT, 2'h0, 11'h000, 1'b0, 32'h0);
    req(sbr_pkg::CMD_PRE, 2'h0, 11'h400, 1'b0, 32'h0);
    req(sbr_pkg::CMD_ACT, 2'h1, 11'h000, 1'b0, 32'h0);
    idle(6);
    check("banks after recovery", 32'(bank_open), 32'h2);
    check("words left", 32'(exp_q.size()), 32'h0);
    check("burst idle", 32'(busy), 32'h0);
    test_done();
  end
endmodule // sbr_burst_read_write_bench
